/* File: hdl/br_block_ram.sv */
// Embedded block RAM with dual-port and two-port modes and error protection.
// Notes on behaviour
// R1 - Storage holds exactly 20,480 bits, usable as dual-port or two-port.
// R2 - Port widths 1, 2, 5, 10, 20, 40, or 33 with protection on.
// R3 - 33-bit words carry single-correct double-detect code and interleaving.
// R4 - Dual-port: both widths under 33, each port reads or writes anywhere.
// R5 - Colliding write completes; a read may be stale; later reads see new.
// R6 - Two-port mode chosen when any port is 40 wide or protected 33.
// R7 - Two-port: first port only reads, second only writes; widths may differ.
// R8 - Each read port has optional output register, own enable and sync reset.
// R9 - Read enable low means no access and read data holds.
// R10 - Inputs registered per port; byte enables limit which lanes change, except at width 33.
`timescale 1ns/1ps
`default_nettype none

module br_block_ram
  import br_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire br_width_type cfgWidthA,
  input wire br_width_type cfgWidthB,
  input wire br_port_type portA,
  input wire br_port_type portB,
  input wire br_outctl_type outCtlA,
  input wire br_outctl_type outCtlB,
  output logic [ROW_BITS-1:0] readDataA,
  output logic [ROW_BITS-1:0] readDataB,
  output logic eccSingleA,
  output logic eccDoubleA,
  output logic twoPortMode
);

  // Rows of 40 bits keep the widest word in one row; 512 rows give the size.
  logic [ROW_BITS-1:0] memArr [ROW_COUNT]; // [R1]
  br_state_type state_reg;
  br_state_type state_next;

  function automatic int perRow(input br_width_type w);
    case (w)
      BR_W1: return 40;
      BR_W2: return 20;
      BR_W5: return 8;
      BR_W10: return 4;
      BR_W20: return 2;
      default: return 1;
    endcase
  endfunction

  function automatic int bitsOf(input br_width_type w);
    case (w)
      BR_W1: return 1;
      BR_W2: return 2;
      BR_W5: return 5;
      BR_W10: return 10;
      BR_W20: return 20;
      BR_W33: return ECC_DATA_BITS;
      default: return ROW_BITS;
    endcase
  endfunction

  function automatic logic isWide(input br_width_type w);
    return (w == BR_W40) || (w == BR_W33); // [R6]
  endfunction

  function automatic logic [ROW_BITS-1:0] widthMask(input br_width_type w);
    logic [ROW_BITS-1:0] m;
    m = '0;
    for (int i = 0; i < ROW_BITS; i++) begin
      m[i] = (i < bitsOf(w)); // [R2]
    end
    return m;
  endfunction

  // Spreading adjacent code bits apart turns a multi-bit upset into
  // scattered single errors in separate positions of the code.
  function automatic logic [ROW_BITS-1:0] interleave(
      input logic [ROW_BITS-1:0] c);
    logic [ROW_BITS-1:0] o;
    o = '0;
    for (int i = 0; i < ROW_BITS; i++) begin
      o[(i * ILV_STEP) % ROW_BITS] = c[i]; // [R3]
    end
    return o;
  endfunction

  function automatic logic [ROW_BITS-1:0] deinterleave(
      input logic [ROW_BITS-1:0] c);
    logic [ROW_BITS-1:0] o;
    o = '0;
    for (int i = 0; i < ROW_BITS; i++) begin
      o[i] = c[(i * ILV_STEP) % ROW_BITS]; // [R3]
    end
    return o;
  endfunction

  function automatic logic [ROW_BITS-1:0] eccEncode(
      input logic [ECC_DATA_BITS-1:0] d);
    logic [ROW_BITS-1:0] code;
    int k;
    logic par;
    code = '0;
    k = 0;
    for (int p = 1; p < ROW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        code[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < ECC_PAR_BITS; b++) begin
      par = 1'b0;
      for (int p = 1; p < ROW_BITS; p++) begin
        if (p[b]) begin
          par = par ^ code[p];
        end
      end
      code[1 << b] = par; // [R3]
    end
    code[0] = ^code[ROW_BITS-1:1];
    return code;
  endfunction

  // Result is {double, single, data}.
  function automatic logic [ECC_DATA_BITS+1:0] eccDecode(
      input logic [ROW_BITS-1:0] c);
    logic [ROW_BITS-1:0] code;
    logic [ECC_PAR_BITS-1:0] syn;
    logic [ECC_DATA_BITS-1:0] d;
    logic odd;
    int k;
    code = c;
    syn = '0;
    d = '0;
    k = 0;
    for (int p = 1; p < ROW_BITS; p++) begin
      if (code[p]) begin
        syn = syn ^ p[ECC_PAR_BITS-1:0];
      end
    end
    odd = ^code;
    if (odd && (int'(syn) < ROW_BITS)) begin
      code[syn] = ~code[syn]; // [R3]
    end
    for (int p = 1; p < ROW_BITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = code[p];
        k++;
      end
    end
    return {(syn != '0) && !odd, odd, d}; // [R3]
  endfunction

  function automatic int rowOf(input br_width_type w,
      input logic [ADDR_BITS-1:0] a);
    return int'(a) / perRow(w);
  endfunction

  function automatic int offOf(input br_width_type w,
      input logic [ADDR_BITS-1:0] a);
    return (int'(a) % perRow(w)) * bitsOf(w);
  endfunction

  // Result is {mask, data} aligned to the row.
  function automatic logic [2*ROW_BITS-1:0] placeWrite(
      input br_width_type w, input br_port_type p);
    logic [ROW_BITS-1:0] laneMask;
    logic [ROW_BITS-1:0] m;
    if (w == BR_W33) begin
      // The code word covers the whole row, so byte enables cannot apply.
      return {{ROW_BITS{1'b1}},
              interleave(eccEncode(p.data[ECC_DATA_BITS-1:0]))}; // [R3]
    end
    laneMask = '0;
    for (int i = 0; i < ROW_BITS; i++) begin
      laneMask[i] = p.byteEn[i / LANE_BITS]; // [R10]
    end
    m = (widthMask(w) & laneMask) << offOf(w, p.addr);
    return {m, (p.data << offOf(w, p.addr)) & m};
  endfunction

  function automatic logic [ROW_BITS-1:0] extract(input br_width_type w,
      input logic [ADDR_BITS-1:0] a, input logic [ROW_BITS-1:0] row);
    return (row >> offOf(w, a)) & widthMask(w);
  endfunction

  logic [ROW_IDX_BITS-1:0] rowA;
  logic [ROW_IDX_BITS-1:0] rowB;
  logic okA;
  logic okB;
  logic writeA;
  logic writeB;
  logic [2*ROW_BITS-1:0] placeA;
  logic [2*ROW_BITS-1:0] placeB;
  logic [ROW_BITS-1:0] newA;
  logic [ROW_BITS-1:0] newB;

  always_comb begin
    okA = rowOf(state_reg.widthA, state_reg.inA.addr) < ROW_COUNT;
    okB = rowOf(state_reg.widthB, state_reg.inB.addr) < ROW_COUNT;
    rowA = ROW_IDX_BITS'(rowOf(state_reg.widthA, state_reg.inA.addr));
    rowB = ROW_IDX_BITS'(rowOf(state_reg.widthB, state_reg.inB.addr));
    writeA = state_reg.inA.writeEn && !state_reg.twoPort && okA; // [R4] [R7]
    writeB = state_reg.inB.writeEn && okB; // [R4] [R7]
    placeA = placeWrite(state_reg.widthA, state_reg.inA);
    placeB = placeWrite(state_reg.widthB, state_reg.inB);
    newA = (memArr[rowA] & ~placeA[2*ROW_BITS-1:ROW_BITS])
         | placeA[ROW_BITS-1:0];
    // Two writes to one row merge; where both ports write a lane, port B's data wins.
    newB = (((writeA && rowA == rowB) ? newA : memArr[rowB])
         & ~placeB[2*ROW_BITS-1:ROW_BITS]) | placeB[ROW_BITS-1:0]; // [R5]
  end

  always_ff @(posedge clock) begin
    if (writeA) begin
      memArr[rowA] <= newA; // [R5]
    end
    if (writeB) begin
      memArr[rowB] <= newB; // [R5]
    end
  end

  always_comb begin
    logic [ECC_DATA_BITS+1:0] dec;
    dec = eccDecode(deinterleave(memArr[rowA]));
    state_next = state_reg;
    state_next.widthA = cfgWidthA;
    state_next.widthB = cfgWidthB;
    state_next.inA = portA; // [R10]
    state_next.inB = portB; // [R10]
    state_next.ctlA = outCtlA;
    state_next.ctlB = outCtlB;
    state_next.twoPort = isWide(cfgWidthA) || isWide(cfgWidthB); // [R6]
    // Reads see the row before this cycle's write, which is the permitted
    // ambiguity on a collision; the next read returns the new value.
    if (state_reg.inA.readEn) begin // [R9]
      if (state_reg.widthA == BR_W33) begin
        state_next.rawA = okA ? ROW_BITS'(dec[ECC_DATA_BITS-1:0]) : '0;
        state_next.errRaw = okA ? dec[ECC_DATA_BITS+1:ECC_DATA_BITS] : '0;
      end else begin
        state_next.rawA = okA ?
          extract(state_reg.widthA, state_reg.inA.addr, memArr[rowA]) : '0;
        state_next.errRaw = ERR_RESET;
      end
    end
    if (state_reg.inB.readEn && !state_reg.twoPort) begin // [R7] [R9]
      state_next.rawB = okB ?
        extract(state_reg.widthB, state_reg.inB.addr, memArr[rowB]) : '0;
    end
    if (!state_reg.ctlA.outRegOn) begin
      state_next.doutA = state_next.rawA;
      state_next.errOut = state_next.errRaw;
    end else if (state_reg.ctlA.outSyncRst) begin // [R8]
      state_next.doutA = DOUT_RESET;
      state_next.errOut = ERR_RESET;
    end else if (state_reg.ctlA.outClkEn) begin // [R8]
      state_next.doutA = state_reg.rawA;
      state_next.errOut = state_reg.errRaw;
    end
    if (!state_reg.ctlB.outRegOn) begin
      state_next.doutB = state_next.rawB;
    end else if (state_reg.ctlB.outSyncRst) begin // [R8]
      state_next.doutB = DOUT_RESET;
    end else if (state_reg.ctlB.outClkEn) begin // [R8]
      state_next.doutB = state_reg.rawB;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign readDataA = state_reg.doutA;
  assign readDataB = state_reg.doutB;
  assign eccSingleA = state_reg.errOut[0];
  assign eccDoubleA = state_reg.errOut[1];
  assign twoPortMode = state_reg.twoPort;

endmodule // br_block_ram

`default_nettype wire

/* File: include/br_pkg.sv */
// Shared constants and types for the embedded block RAM.
`default_nettype none
package br_pkg;

  localparam int MEM_BITS = 20480;
  localparam int ROW_BITS = 40;
  localparam int ROW_COUNT = MEM_BITS / ROW_BITS;
  localparam int ROW_IDX_BITS = 9;
  localparam int ADDR_BITS = 15;
  localparam int ECC_DATA_BITS = 33;
  localparam int ECC_PAR_BITS = 6;
  localparam int ILV_STEP = 7;
  localparam int LANE_BITS = 10;
  localparam int BE_BITS = 4;
  localparam logic [39:0] DOUT_RESET = 40'h00_0000_0000;
  localparam logic [1:0] ERR_RESET = 2'h0;

  typedef enum logic [2:0] {
    BR_W1 = 3'b000,
    BR_W2 = 3'b001,
    BR_W5 = 3'b010,
    BR_W10 = 3'b011,
    BR_W20 = 3'b100,
    BR_W40 = 3'b101,
    BR_W33 = 3'b110
  } br_width_type;

  typedef struct packed {
    logic readEn;
    logic writeEn;
    logic [ADDR_BITS-1:0] addr;
    logic [ROW_BITS-1:0] data;
    logic [BE_BITS-1:0] byteEn;
  } br_port_type;

  typedef struct packed {
    logic outRegOn;
    logic outClkEn;
    logic outSyncRst;
  } br_outctl_type;

  typedef struct packed {
    br_width_type widthA;
    br_width_type widthB;
    br_port_type inA;
    br_port_type inB;
    br_outctl_type ctlA;
    br_outctl_type ctlB;
    logic twoPort;
    logic [ROW_BITS-1:0] rawA;
    logic [ROW_BITS-1:0] rawB;
    logic [ROW_BITS-1:0] doutA;
    logic [ROW_BITS-1:0] doutB;
    logic [1:0] errRaw;
    logic [1:0] errOut;
  } br_state_type;

endpackage

`default_nettype wire

/* File: bench/br_block_ram_monitor.sv */
// Port-level assertion checker for the block RAM.
`timescale 1ns/1ps
`default_nettype none
module br_block_ram_monitor
  import br_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire br_width_type cfgWidthA,
  input wire br_width_type cfgWidthB,
  input wire br_port_type portA,
  input wire br_port_type portB,
  input wire br_outctl_type outCtlA,
  input wire br_outctl_type outCtlB,
  input wire logic [ROW_BITS-1:0] readDataA,
  input wire logic [ROW_BITS-1:0] readDataB,
  input wire logic eccSingleA,
  input wire logic eccDoubleA,
  input wire logic twoPortMode
);
  logic [1:0] age;
  logic [39:0] maskA;
  logic wide;
  logic quietA;
  logic quietB;
  assign wide = cfgWidthA inside {BR_W40, BR_W33} ||
                cfgWidthB inside {BR_W40, BR_W33};
  assign quietA = !portA.readEn && outCtlA == 3'h0;
  assign quietB = twoPortMode && outCtlB == 3'h0;
  always_comb begin
    case (cfgWidthA)
      BR_W1: maskA = 40'h00_0000_0001;
      BR_W2: maskA = 40'h00_0000_0003;
      BR_W5: maskA = 40'h00_0000_001f;
      BR_W10: maskA = 40'h00_0000_03ff;
      BR_W20: maskA = 40'h00_000f_ffff;
      BR_W33: maskA = 40'h01_ffff_ffff;
      default: maskA = 40'hff_ffff_ffff;
    endcase
  end
  // Past values are trusted only once three edges follow reset.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_mode_set: assert property (age == 2'h3 && wide && $past(wide) &&
    $past(wide, 2) |-> twoPortMode) else $error("two-port mode missing");
  a_mode_clear: assert property (age == 2'h3 && !wide &&
    !$past(wide) && !$past(wide, 2) |-> !twoPortMode)
    else $error("dual mode missing");
  // Controls act one edge late, so hold needs three quiet samples.
  a_read_hold: assert property (age == 2'h3 && $past(quietA) &&
    $past(quietA, 2) && $past(quietA, 3) |-> $stable(readDataA))
    else $error("A data moved");
  a_write_only_b: assert property (age == 2'h3 && quietB &&
    $past(quietB) && $past(quietB, 2) && $past(quietB, 3) |->
    $stable(readDataB))
    else $error("B read in two-port mode");
  a_width_zero: assert property (age == 2'h3 &&
    $past(portA.readEn, 2) &&
    $past(outCtlA) == 3'h0 && $past(outCtlA, 2) == 3'h0 &&
    $past(cfgWidthA) == cfgWidthA && $past(cfgWidthA, 2) == cfgWidthA
    |-> (readDataA & ~maskA) == 40'h0) else $error("bits above width");
  a_ecc_exclusive: assert property (!(eccSingleA && eccDoubleA))
    else $error("both error flags");
  a_flags_plain: assert property (age == 2'h3 &&
    $past(portA.readEn, 2) && $past(cfgWidthA, 2) != BR_W33 &&
    $past(outCtlA, 2) == 3'h0 |-> !eccSingleA && !eccDoubleA)
    else $error("error flag on plain read");
  a_sync_rst_a: assert property (outCtlA.outSyncRst && outCtlA.outRegOn
    |-> ##2 readDataA == 40'h0) else $error("A sync reset missed");
  a_sync_rst_b: assert property (outCtlB.outSyncRst && outCtlB.outRegOn
    |-> ##2 readDataB == 40'h0) else $error("B sync reset missed");
endmodule // br_block_ram_monitor
bind br_block_ram br_block_ram_monitor mon (.clock, .rst_b, .cfgWidthA,
  .cfgWidthB, .portA, .portB, .outCtlA, .outCtlB, .readDataA, .readDataB,
  .eccSingleA, .eccDoubleA, .twoPortMode);
`default_nettype wire

/* File: bench/br_user_model.sv */
// Fabric-side model that drives both memory ports.
`timescale 1ns/1ps
`default_nettype none
module br_user_model
  import br_pkg::*;
(
  input wire logic clock,
  output var br_port_type portA,
  output var br_port_type portB
);
  initial begin
    portA = '0;
    portB = '0;
  end
  // Idle ports carry inverted leftovers so a design that ignores the
  // enables cannot lean on a convenient stale value.
  function automatic br_port_type released(input br_port_type p);
    released = ~p;
    released.readEn = 1'b0;
    released.writeEn = 1'b0;
  endfunction
  task automatic access(input br_port_type a, input br_port_type b);
    @(negedge clock);
    portA = a;
    portB = b;
    @(negedge clock);
    portA = released(a);
    portB = released(b);
  endtask
endmodule // br_user_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking testbench for the block RAM.
`timescale 1ns/1ps
`default_nettype none
module tb
  import br_pkg::*;
;
  logic clock, rst_b, eccSingleA, eccDoubleA, twoPortMode;
  br_width_type cfgWidthA, cfgWidthB;
  br_outctl_type outCtlA, outCtlB;
  br_port_type portA, portB;
  logic [39:0] readDataA, readDataB;
  int fails, totalChecks;
  localparam br_port_type NOP = '0;
  localparam logic [39:0] V = 40'hc3_5a0f_1e2d;
  br_block_ram dut (.clock, .rst_b, .cfgWidthA, .cfgWidthB, .portA, .portB,
    .outCtlA, .outCtlB, .readDataA, .readDataB, .eccSingleA, .eccDoubleA,
    .twoPortMode);
  br_user_model user (.clock, .portA, .portB);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic br_port_type op(input logic rd, input logic wr,
    input int adr, input logic [39:0] d, input logic [3:0] be);
    op = '{readEn: rd, writeEn: wr, addr: adr[14:0], data: d, byteEn: be};
  endfunction
  task automatic go(input br_port_type a, input br_port_type b, input int n);
    user.access(a, b);
    repeat (n) @(negedge clock);
  endtask
  task automatic cfg(input br_width_type wa, input br_width_type wb);
    @(negedge clock);
    cfgWidthA = wa;
    cfgWidthB = wb;
    repeat (3) @(negedge clock);
  endtask
  task automatic t_dual;
    cfg(BR_W10, BR_W10);
    chk({39'h0, twoPortMode}, 40'h0);
    go(op(0, 1, 3, 40'h2a5, 4'h1), op(0, 1, 5, 40'h3c3, 4'h1), 0);
    go(op(1, 0, 5, 0, 0), op(1, 0, 3, 0, 0), 1);
    chk(readDataA, 40'h3c3);
    chk(readDataB, 40'h2a5);
    go(NOP, op(0, 1, 3, 40'h0, 4'h0), 2);
    chk(readDataA, 40'h3c3);
    go(op(1, 0, 3, 0, 0), NOP, 1);
    chk(readDataA, 40'h2a5);
    go(op(1, 0, 7, 0, 0), op(0, 1, 7, 40'h155, 4'h1), 0);
    go(op(1, 0, 7, 0, 0), NOP, 1);
    chk(readDataA, 40'h155);
  endtask
  task automatic t_widths;
    br_width_type codes[5] = '{BR_W1, BR_W2, BR_W5, BR_W20, BR_W10};
    int bits[5] = '{1, 2, 5, 20, 10};
    logic [39:0] v;
    int last;
    for (int i = 0; i < 5; i++) begin
      cfg(codes[i], codes[i]);
      last = MEM_BITS / bits[i] - 1;
      v = 40'h55_5555_5555 & ((40'h1 << bits[i]) - 40'h1);
      go(NOP, op(0, 1, last, v, 4'hf), 0);
      go(op(1, 0, last, 0, 0), NOP, 1);
      chk(readDataA, v);
      go(op(1, 0, last + 1, 0, 0), NOP, 1);
      chk(readDataA, 40'h0);
    end
  endtask
  task automatic t_two;
    cfg(BR_W40, BR_W40);
    chk({39'h0, twoPortMode}, 40'h1);
    go(NOP, op(0, 1, 9, V, 4'hf), 0);
    go(op(1, 0, 9, 0, 0), op(1, 0, 9, 0, 0), 1);
    chk(readDataA, V);
    chk(readDataB, 40'h2a5);
    go(op(0, 1, 9, ~V, 4'hf), NOP, 0);
    go(op(1, 0, 9, 0, 0), NOP, 1);
    chk(readDataA, V);
    cfg(BR_W10, BR_W40);
    go(op(1, 0, 37, 0, 0), NOP, 1);
    chk(readDataA, (V >> 10) & 40'h3ff);
    cfg(BR_W33, BR_W33);
    go(NOP, op(0, 1, 11, 40'h1_2345_6789, 4'hf), 0);
    go(op(1, 0, 11, 0, 0), NOP, 1);
    chk(readDataA, 40'h1_2345_6789);
    chk({38'h0, eccSingleA, eccDoubleA}, 40'h0);
  endtask
  task automatic t_reset;
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    chk(readDataA, 40'h0);
    chk(readDataB, 40'h0);
    chk({39'h0, twoPortMode}, 40'h0);
    rst_b = 1'b1;
    go(op(1, 0, 11, 0, 0), NOP, 1);
    chk(readDataA, 40'h1_2345_6789);
    chk({39'h0, twoPortMode}, 40'h1);
  endtask
  task automatic t_outreg;
    cfg(BR_W10, BR_W10);
    chk({39'h0, twoPortMode}, 40'h0);
    outCtlA = 3'b110;
    go(op(1, 0, 3, 0, 0), NOP, 1);
    chk(readDataA, 40'h1_2345_6789);
    @(negedge clock);
    chk(readDataA, 40'h2a5);
    outCtlA = 3'b100;
    outCtlB = 3'b110;
    go(op(1, 0, 5, 0, 0), op(1, 0, 5, 0, 0), 3);
    chk(readDataA, 40'h2a5);
    chk(readDataB, 40'h3c3);
    outCtlA = 3'b101;
    outCtlB = 3'b101;
    repeat (3) @(negedge clock);
    chk(readDataA, 40'h0);
    chk(readDataB, 40'h0);
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    cfgWidthA = BR_W10;
    cfgWidthB = BR_W10;
    outCtlA = 3'b000;
    outCtlB = 3'b000;
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    t_dual();
    t_widths();
    t_two();
    t_reset();
    t_outreg();
    results();
  end
endmodule // tb
`default_nettype wire
